// [trs_cfg.svh]
// Constants of the terminal read sequencer: offsets, fields, reset values, timing.
// Assumes a 100 MHz clock and a 32-bit AHB-Lite register bus.
`ifndef TRS_CFG_SVH
`define TRS_CFG_SVH
`define TRS_CLK_NS        10
`define TRS_GAP_NS        7000
`define TRS_STAGE_A_DELAY_TIMER_NS       2000
`define TRS_STAGE_B_DELAY_TIMER_NS       4000
`define TRS_SETTLE_NS     500
`define TRS_GAP_CYC       ((`TRS_GAP_NS + `TRS_CLK_NS - 1) / `TRS_CLK_NS)
`define TRS_STAGE_A_DELAY_TIMER_CYC      (`TRS_STAGE_A_DELAY_TIMER_NS / `TRS_CLK_NS)
`define TRS_STAGE_B_DELAY_TIMER_CYC      (`TRS_STAGE_B_DELAY_TIMER_NS / `TRS_CLK_NS)
`define TRS_SETTLE_CYC    ((`TRS_SETTLE_NS + `TRS_CLK_NS - 1) / `TRS_CLK_NS)
`define TRS_OFS_CTRL      2'h0
`define TRS_OFS_STATUS    2'h1
`define TRS_OFS_COUNT     2'h2
`define TRS_CTRL_SRST     0
`define TRS_CTRL_PLUG     1
`define TRS_PLUG_RST      1'b1
`define TRS_READY_BIT     1
`define TRS_TYPE_XLATE    3'h2
`define TRS_TERM_GM       8'h7d
`define TRS_HOST_GM       6'h1f
`endif

// [trs_pkg.sv]
// Types of the terminal read sequencer: pin bundles, states and the state record.
// Used by trs_read_sequencer, trs_chk_sva, trs_term_model and the testbench.
package trs_pkg;
  typedef enum logic [7:0] {
    TRS_IDLE = 8'h01,
    TRS_SYNC = 8'h02,
    TRS_CHK  = 8'h04,
    TRS_STAT = 8'h08,
    TRS_SEND = 8'h10,
    TRS_XF0  = 8'h20,
    TRS_XF   = 8'h40,
    TRS_END  = 8'h80
  } trs_state_e;
  typedef struct packed {
    logic       sync_request;
    logic       read_request;
    logic [5:0] host_info;
    logic       unit_ready_line;
    logic       unit_char_strobe;
    logic [3:0] unit_status;
    logic [2:0] unit_type;
    logic [7:0] unit_info;
  } trs_pins_s;
  typedef struct packed {
    logic [5:0] info;
    logic       host_char_strobe;
    logic       host_read_ready_flag;
  } trs_host_s;
  typedef struct packed {
    logic       unit_char_request;
    logic [3:0] unit_number;
  } trs_unit_s;
  typedef struct packed {
    trs_pins_s  s1;
    trs_pins_s  s2;
    trs_state_e st;
    logic       stage_a_full;
    logic       stage_b_full;
    logic       char_request_inhibit;
    logic [9:0] a_tmr;
    logic [9:0] b_tmr;
    logic [9:0] gap;
    logic [3:0] status;
    logic [2:0] utype;
    logic [7:0] stage1;
    logic       gm_seen;
    logic [6:0] nchar;
    logic       plug_en;
    logic       soft_rst;
    logic       dp_wr;
    logic [1:0] dp_idx;
    logic [31:0] hrdata;
    logic       hreadyout;
    logic       hresp;
    trs_host_s  host;
    trs_unit_s  unit;
  } trs_regs_s;
endpackage : trs_pkg

// [trs_read_sequencer.sv]
// Read-transfer sequencer between a host processor and one terminal unit.
// Holds the state sequence, the two-stage character path and a small AHB-Lite slave.
// Assumes host and terminal pins are asynchronous and AHB-Lite runs on hclk.
// Assumes a single slave, so hreadyout is also the bus hready.
`timescale 1ns/1ns
`include "trs_cfg.svh"

// Operation
// - Move whole 87-char buffer plus group mark
// - Idle sync request sets state_q_bit2
// - Latch unit number, go to P5 Q0
// - Load only with plug option, zones zero
// - B clock tests ready, sets B, clears A
// - A clock picks Q1 or Q3
// - Capture status and type on unit strobe
// - Read-ready line sets read_ready_bit
// - Type 2 selects code translation
// - First B sends unit number, flag
// - Host strobe waits half microsecond settle
// - Second B after 7us clears B
// - One strobe, then P1 Q0, P1 Q1
// - Request next char once first stage loads
// - Chars pass stage, translator, output register
// - Wait in P1 Q3 for status change
// - Sync drop: P1 if read-ready, else idle
// - A clock free runs, alternate inhibit, load
// - B loads translator output, triggers strobe timer
module trs_read_sequencer
  import trs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  input  wire trs_pins_s   pins,
  output      trs_host_s   host,
  output      trs_unit_s   unit
);

  trs_regs_s r;
  trs_regs_s n;
  logic      a_pulse;
  logic      b_pulse;
  logic      a_to;
  logic      gap_ok;
  logic      sel;

  // Ready-flag decoding is shared by the host flag, the sync-drop branch and the end wait
  function automatic logic trs_rdy(input logic [3:0] s);
    trs_rdy = s[`TRS_READY_BIT];
  endfunction : trs_rdy

  // Group mark decoding is shared by the translator and the end-of-buffer test
  function automatic logic trs_is_gm(input logic [7:0] c);
    trs_is_gm = (c == `TRS_TERM_GM);
  endfunction : trs_is_gm

  // Terminal to host code for type 2; other types pass their low bits, every type maps the group mark
  function automatic logic [5:0] trs_xlate(input logic [7:0] c, input logic [2:0] t);
    if (trs_is_gm(c)) begin
      trs_xlate = `TRS_HOST_GM;
    end else if (t == `TRS_TYPE_XLATE) begin
      trs_xlate = {c[6] ^ c[5], c[4], c[3:0]};
    end else begin
      trs_xlate = c[5:0];
    end
  endfunction : trs_xlate

  // Register map, word index on haddr[3:2]
  // CTRL   [0] soft reset, write only, reads 0; [1] plug option enable
  // STATUS [7:0] one-hot state, [8] stage A full, [9] stage B full,
  //        [10] request inhibit, [14:11] unit status, [17:15] unit type,
  //        [21:18] unit number
  // COUNT  [6:0] characters forwarded, group mark included; [7] mark seen
  function automatic logic [31:0] trs_rd_word(input trs_regs_s q, input logic [1:0] idx);
    case (idx)
      `TRS_OFS_CTRL:   trs_rd_word = {30'h0, q.plug_en, 1'b0};
      `TRS_OFS_STATUS: trs_rd_word = {10'h0, q.unit.unit_number, q.utype, q.status,
                                      q.char_request_inhibit, q.stage_b_full,
                                      q.stage_a_full, q.st};
      `TRS_OFS_COUNT:  trs_rd_word = {24'h0, q.gm_seen, q.nchar};
      default:         trs_rd_word = 32'h0;
    endcase
  endfunction : trs_rd_word

  // Strobe only after the settle time and with the first stage empty
  function automatic logic trs_strobe(input logic [9:0] t, input logic a_full);
    trs_strobe = (t != 10'd0) && !a_full && (t <= 10'(`TRS_STAGE_B_DELAY_TIMER_CYC - `TRS_SETTLE_CYC));
  endfunction : trs_strobe

  // Ask for a character only in the transfer state with the inhibit clear
  function automatic logic trs_req(input trs_state_e s, input logic inh);
    trs_req = (s == TRS_XF) && !inh;
  endfunction : trs_req

  assign sel = hsel & hready & htrans[1];

  always_comb begin
    n       = r;
    a_pulse = 1'b0;
    b_pulse = 1'b0;
    // Two flops on every pin; the logic reads only the second
    n.s1    = pins;
    n.s2    = r.s1;
    n.soft_rst = 1'b0;
    // Monostables as down counters; the timeout is the step from 1 to 0
    a_to = (r.a_tmr == 10'd1);
    if (r.a_tmr != 10'd0) begin
      n.a_tmr = r.a_tmr - 10'd1;
    end
    if (r.b_tmr != 10'd0) begin
      n.b_tmr = r.b_tmr - 10'd1;
    end
    // Saturates at the minimum spacing, so a long pause allows the next pulse at once
    gap_ok = (r.gap == 10'(`TRS_GAP_CYC));
    if (!gap_ok) begin
      n.gap = r.gap + 10'd1;
    end
    case (r.st)
      TRS_IDLE: begin
        if (r.s2.sync_request && gap_ok) begin
          a_pulse = 1'b1;
          n.st    = TRS_SYNC;
        end
      end
      TRS_SYNC: begin
        // A number with zone bits set never loads; the host is expected to retry
        if (r.s2.sync_request && r.s2.read_request && gap_ok &&
            r.plug_en && (r.s2.host_info[5:4] == 2'b00)) begin
          a_pulse           = 1'b1;
          n.unit.unit_number = r.s2.host_info[3:0];
          // A skipped capture must not pass on the last unit's read-ready
          n.status          = 4'h0;
          n.st              = TRS_CHK;
          n.stage_a_full    = 1'b1;
          n.a_tmr           = 10'(`TRS_STAGE_A_DELAY_TIMER_CYC);
        end
      end
      TRS_CHK: begin
        if (a_to) begin
          b_pulse        = 1'b1;
          n.stage_b_full = r.s2.unit_ready_line;
          n.stage_a_full = 1'b0;
        end else if (!r.stage_a_full && gap_ok) begin
          // A unit found not ready skips the capture, which waits on its strobe
          a_pulse = 1'b1;
          if (r.stage_b_full) begin
            n.st = TRS_STAT;
          end else begin
            n.st           = TRS_SEND;
            n.stage_a_full = 1'b1;
            n.a_tmr        = 10'(`TRS_STAGE_A_DELAY_TIMER_CYC);
          end
        end
      end
      TRS_STAT: begin
        if (r.s2.unit_char_strobe && gap_ok) begin
          a_pulse        = 1'b1;
          n.status       = r.s2.unit_status;
          n.utype        = r.s2.unit_type;
          n.stage_a_full = 1'b1;
          n.stage_b_full = 1'b0;
          n.a_tmr        = 10'(`TRS_STAGE_A_DELAY_TIMER_CYC);
          n.st           = TRS_SEND;
        end
      end
      TRS_SEND: begin
        if (a_to) begin
          b_pulse                     = 1'b1;
          n.host.info                 = {2'b00, r.unit.unit_number};
          n.host.host_read_ready_flag = trs_rdy(r.status);
          n.b_tmr                     = 10'(`TRS_STAGE_B_DELAY_TIMER_CYC);
          n.stage_a_full              = 1'b0;
          n.stage_b_full              = 1'b1;
        end else if (!r.stage_a_full && r.stage_b_full && gap_ok &&
                     (r.b_tmr == 10'd0)) begin
          b_pulse        = 1'b1;
          // This pulse only frees stage B, which re-enables the A clock
          n.stage_b_full = 1'b0;
        end else if (!r.stage_a_full && !r.stage_b_full && gap_ok &&
                     !r.s2.sync_request) begin
          a_pulse = 1'b1;
          // The host drops sync once it has taken the unit number
          n.st    = trs_rdy(r.status) ? TRS_XF0 : TRS_IDLE;
          n.nchar = 7'd0;
          n.gm_seen = 1'b0;
          n.host.host_read_ready_flag = 1'b0;
        end
      end
      TRS_XF0: begin
        if (gap_ok) begin
          a_pulse                = 1'b1;
          n.st                   = TRS_XF;
          n.char_request_inhibit = 1'b0;
        end
      end
      TRS_XF: begin
        if (a_to) begin
          b_pulse        = 1'b1;
          n.host.info    = trs_xlate(r.stage1, r.utype);
          n.stage_b_full = 1'b1;
          n.stage_a_full = 1'b0;
          n.b_tmr        = 10'(`TRS_STAGE_B_DELAY_TIMER_CYC);
          n.gm_seen      = trs_is_gm(r.stage1);
          n.nchar        = r.nchar + 7'd1;
        end else if (r.b_tmr == 10'd1) begin
          // End of the strobe timer frees stage B for the next character
          n.stage_b_full = 1'b0;
          if (r.gm_seen) begin
            n.st = TRS_END;
          end
        end else if (r.s2.unit_char_strobe && gap_ok && !r.gm_seen) begin
          // Odd pulses only drop the request; the next one loads stage A
          if (!r.char_request_inhibit) begin
            a_pulse                = 1'b1;
            n.char_request_inhibit = 1'b1;
          end else if (!r.stage_a_full) begin
            a_pulse                = 1'b1;
            n.stage1               = r.s2.unit_info;
            n.stage_a_full         = 1'b1;
            n.a_tmr                = 10'(`TRS_STAGE_A_DELAY_TIMER_CYC);
            n.char_request_inhibit = 1'b0;
          end
        end
      end
      TRS_END: begin
        // The terminal drops read-ready once it has taken the group mark
        if (!trs_rdy(r.s2.unit_status) && gap_ok) begin
          a_pulse = 1'b1;
          n.st    = TRS_IDLE;
        end
      end
      default: begin
        n.st = TRS_IDLE;
      end
    endcase
    // Every pulse restarts the spacing count
    if (a_pulse || b_pulse) begin
      n.gap = 10'd0;
    end
    // Captured registers and the count survive a soft reset for inspection
    if (r.soft_rst) begin
      n.st                   = TRS_IDLE;
      n.stage_a_full         = 1'b0;
      n.stage_b_full         = 1'b0;
      n.char_request_inhibit = 1'b0;
      n.a_tmr                = 10'd0;
      n.b_tmr                = 10'd0;
    end
    n.host.host_char_strobe  = trs_strobe(n.b_tmr, n.stage_a_full);
    n.unit.unit_char_request = trs_req(n.st, n.char_request_inhibit);
    // Register bus: zero wait states, read data fetched in the address phase
    // Every transfer is decoded as a single word; hsize is not looked at
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;
    n.dp_wr     = sel & hwrite;
    n.dp_idx    = haddr[3:2];
    if (sel && !hwrite) begin
      n.hrdata = trs_rd_word(r, haddr[3:2]);
    end
    if (r.dp_wr && (r.dp_idx == `TRS_OFS_CTRL)) begin
      n.plug_en  = hwdata[`TRS_CTRL_PLUG];
      n.soft_rst = hwdata[`TRS_CTRL_SRST];
    end
  end

  // Clock enable low freezes every flop, bus slave included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.st        <= TRS_IDLE;
      r.plug_en   <= `TRS_PLUG_RST;
      r.hreadyout <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hrdata    = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp     = r.hresp;
  assign host      = r.host;
  assign unit      = r.unit;

endmodule : trs_read_sequencer

// [trs_chk_sva.sv]
// Checker of the read sequencer ports: host strobe timing, handshakes, bus answer.
// Bound to every trs_read_sequencer; sees its ports only.
`timescale 1ns/1ns
module trs_chk_sva
  import trs_pkg::*;
(
  input wire logic      hclk,
  input wire logic      hresetn,
  input wire logic      hreadyout,
  input wire logic      hresp,
  input wire trs_pins_s pins,
  input wire trs_host_s host,
  input wire trs_unit_s unit
);
  logic        s;
  logic        sp;
  logic [10:0] since;
  logic [10:0] wid;
  assign s = host.host_char_strobe;
  // The saturating since count keeps the gap check quiet right after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp <= 1'b0;
      since <= 11'h7ff;
      wid <= 11'h0;
    end else begin
      sp <= s;
      wid <= s ? wid + 11'h1 : 11'h0;
      since <= (s && !sp) ? 11'h0 : ((since == 11'h7ff) ? since : since + 11'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence quiet;
    !s [*8];
  endsequence
  sequence held;
    $stable({host.info, host.host_read_ready_flag}) [*8];
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_ready_high: assert property (hreadyout)
    else $error("bus stalled");
  a_info_settle: assert property ($changed(host.info) |-> quiet)
    else $error("strobe too soon after data");
  a_info_hold: assert property ($rose(s) |-> held)
    else $error("data moved under strobe");
  a_strobe_gap: assert property ($rose(s) |-> since >= 11'h2bc)
    else $error("strobes closer than gap");
  a_strobe_width: assert property ($fell(s) |-> wid >= 11'h12c && wid <= 11'h190)
    else $error("strobe width wrong");
  a_req_after_sync: assert property ($rose(unit.unit_char_request) |-> !pins.sync_request)
    else $error("request while sync held");
  a_number_held: assert property (unit.unit_char_request |-> $stable(unit.unit_number))
    else $error("unit number moved");
endmodule : trs_chk_sva
bind trs_read_sequencer trs_chk_sva u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .host(host), .unit(unit));

// [trs_term_model.sv]
// Terminal unit model: ready line, status, type and buffer characters.
// Assumes the sequencer's unit_char_request is the only handshake.
`timescale 1ns/1ns
module trs_term_model
  import trs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       rdy,
  input  wire logic       arm,
  input  wire logic       rrin,
  input  wire logic [6:0] n,
  input  wire trs_unit_s  unit,
  output      logic       ready_ln,
  output      logic       strobe,
  output      logic [3:0] status,
  output      logic [2:0] utype,
  output      logic [7:0] info
);
  logic [6:0] k = 7'h0;
  logic       rr = 1'b0;
  logic       first = 1'b0;
  logic       rq = 1'b0;
  logic [7:0] ch;
  assign ch = (k == n) ? 8'h7d : {1'b0, k};
  assign ready_ln = rdy;
  assign strobe = rdy;
  assign status = {~rr, 1'b0, rr, 1'b0};
  assign utype = 3'h2;
  // Unpowered unit shows the inverse of its current character, not the character itself
  assign info = rdy ? ch : ~ch;
  always @(posedge hclk) begin
    rq <= unit.unit_char_request;
    if (arm) begin
      k <= 7'h0;
      rr <= rrin;
      first <= 1'b1;
    end else if (unit.unit_char_request && !rq) begin
      if (first) first <= 1'b0;
      else if (k == n) rr <= 1'b0;
      else k <= k + 7'h1;
    end
  end
endmodule : trs_term_model

// [trs_read_sequencer_tb.sv]
// Testbench of the read sequencer: host side and AHB master here, terminal in the model.
// Needs trs_term_model and the bound checker.
`timescale 1ns/1ns
module trs_read_sequencer_tb import trs_pkg::*;;
  logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic        hreadyout, hresp, sp = 0, url, ucs;
  logic        sync = 0, rd = 0, rdy = 0, arm = 0, rrin = 0;
  logic [5:0]  hinfo = 0;
  logic [6:0]  n = 0;
  logic [3:0]  ust;
  logic [2:0]  uty;
  logic [7:0]  uin;
  trs_pins_s   pins;
  trs_host_s   host;
  trs_unit_s   unit;
  logic [5:0]  qi[$];
  logic        qf[$];
  int          failures = 0, checks = 0, cyc = 0;
  assign pins = {sync, rd, hinfo, url, ucs, ust, uty, uin};
  trs_read_sequencer uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pins(pins), .host(host), .unit(unit));
  trs_term_model term (.hclk(hclk), .rdy(rdy), .arm(arm), .rrin(rrin), .n(n),
    .unit(unit), .ready_ln(url), .strobe(ucs), .status(ust), .utype(uty), .info(uin));
  always #5 hclk = ~hclk;
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Host side of the model: every strobe is one result, sampled where it has settled
  always @(negedge hclk) begin
    sp <= host.host_char_strobe;
    if (host.host_char_strobe === 1'b1 && sp === 1'b0) begin
      qi.push_back(host.info);
      qf.push_back(host.host_read_ready_flag);
    end
    cyc++;
    if (cyc > 90000) begin
      failures++;
      print_verdict;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : cmp
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus
  task wq(input int m, input int lim);
    for (int i = 0; i < lim && qi.size() < m; i++) @(posedge hclk);
  endtask : wq
  task start(input logic [5:0] num, input logic ry, input logic rr, input int nch);
    qi.delete();
    qf.delete();
    @(posedge hclk);
    {rdy, rrin, arm, sync, rd, hinfo, n} <= {ry, rr, 3'h7, num, 7'(nch)};
    @(posedge hclk);
    arm <= 0;
  endtask : start
  task run(input logic [3:0] num, input logic ry, input logic rr, input int nch);
    start({2'h0, num}, ry, rr, nch);
    wq(1, 4000);
    cmp(qi[0], {2'h0, num}, "unit number");
    cmp(qf[0], ry & rr, "ready flag");
    {sync, rd} <= 2'h0;
    if (ry & rr) begin
      wq(nch + 2, nch * 1700 + 5000);
      cmp(qi.size(), nch + 2, "char count");
      cmp(qi[nch + 1], 6'h1f, "group mark");
      for (int i = 1; i <= nch; i++) cmp(qi[i], 6'(i - 1), "character");
      bus(0, 32'h8, 0);
      cmp(r, {24'h0, 1'b1, 7'(nch + 1)}, "count");
      bus(0, 32'h4, 0);
      cmp(r[17:11], {3'h2, 4'h2}, "type status");
    end
    repeat (1600) @(posedge hclk);
    cmp(qi.size(), (ry & rr) ? nch + 2 : 1, "extra strobe");
    bus(0, 32'h4, 0);
    cmp(r[7:0], 8'h01, "not idle");
    $display("read done, %0d strobes", qi.size());
  endtask : run
  task stall(input logic [1:0] z);
    start({z, 4'h5}, 1, 1, 2);
    repeat (3000) @(posedge hclk);
    cmp(qi.size(), 0, "refused read ran");
    bus(0, 32'h4, 0);
    cmp(r[7:0], 8'h02, "left sync");
    {sync, rd} <= 2'h0;
    bus(1, 32'h0, 32'h3);
    bus(0, 32'h4, 0);
    cmp(r[10:0], 11'h001, "soft reset");
    $display("refusal done");
  endtask : stall
  initial begin
    r = $urandom(32'h8e05);
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    bus(0, 32'h0, 0);
    cmp(r, 32'h2, "ctrl reset");
    bus(0, 32'hc, 0);
    cmp(r, 32'h0, "unmapped");
    run(4'($urandom), 0, 0, 0);
    run(4'($urandom), 1, 0, 0);
    run(4'($urandom), 1, 1, 3 + $urandom % 8);
    stall(2'h2);
    bus(1, 32'h0, 32'h0);
    stall(2'h0);
    run(4'hf, 1, 1, 0);
    run(4'($urandom), 0, 0, 0);
    print_verdict;
  end
endmodule : trs_read_sequencer_tb
